/* include/msr_pkg.sv */
package msr_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_CLR_OFS  = 8'h0C;
   localparam logic [7:0] IRQ_EN_OFS   = 8'h10;
   localparam logic [7:0] SEED_OFS     = 8'h14;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_MAN_EN   = 0;
   localparam int CTRL_MAN_MST  = 1;
   localparam int CTRL_LOOP_SUP = 2;
   localparam int CTRL_START    = 3;
   localparam int ST_DONE       = 0;
   localparam int ST_MASTER     = 1;
   localparam int ST_RES_FLT    = 2;
   localparam int ST_CFG_FLT    = 3;
   localparam int ST_LINK_OK    = 4;
   localparam int ST_CLK_REC    = 5;
   localparam int ST_CNT_LSB    = 8;
   localparam int ST_BUSY       = 15;
   localparam int EV_DONE       = 0;
   localparam int EV_RES_FLT    = 1;
   localparam int EV_CFG_FLT    = 2;
   // ------------------------------------------------------------
   // Sizes, counts, reset values
   // ------------------------------------------------------------
   localparam int         SEED_W     = 11;
   localparam int         CNT_W      = 3;
   localparam int         EV_W       = 3;
   localparam logic [2:0] MAX_SEEDS  = 3'h7;
   localparam logic [2:0] CTRL_RST   = 3'h0;
   localparam logic [2:0] IRQ_EN_RST = 3'h0;
   localparam logic [10:0] LFSR_RST  = 11'h5A5;
   localparam logic [10:0] LFSR_TAPS = 11'h500;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MSR_IDLE,
      MSR_SEND,
      MSR_WAIT,
      MSR_DONE
   } msr_state_type;
endpackage

/* src/msr_resolver.sv */
`timescale 1ns/10ps
module msr_resolver (
   input  wire logic                        clk_sys,      // 100 MHz
   input  wire logic                        rst_n,        // Async reset
   input  wire logic                        ce,           // Clock enable
   input  wire logic                        an_start,     // Begin resolution
   input  wire logic                        lp_valid,     // Partner page in
   input  wire logic                        lp_man_en,    // Partner manual
   input  wire logic                        lp_man_mst,   // Partner wants MST
   input  wire logic                        lp_loop_sup,  // Partner loop time
   input  wire logic [msr_pkg::SEED_W-1:0]  lp_seed,      // Partner seed
   output logic                             loc_valid,    // Local page out
   output logic                             loc_man_en,   // Local manual
   output logic                             loc_man_mst,  // Local wants MST
   output logic                             loc_loop_sup, // Local loop time
   output logic [msr_pkg::SEED_W-1:0]       loc_seed,     // Local seed
   output logic                             role_master,  // 1 MASTER
   output logic                             res_done,     // Complete
   output logic                             res_fault,    // Seed fault
   output logic                             cfg_fault,    // Role conflict
   output logic                             link_ok_indication, // Link ok
   output logic                             clk_sel_recovered,  // Tx clk src
   output logic                             irq,          // Interrupt
   input  wire logic [7:0]                  s_axi_awaddr, // AXI-Lite
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [7:0]                  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      msr_pkg::msr_state_type          st;
      logic [msr_pkg::CNT_W-1:0]       cnt;
      logic [msr_pkg::SEED_W-1:0]      lfsr;
      logic [msr_pkg::SEED_W-1:0]      seed;
      logic                            loc_valid;
      logic                            master;
      logic                            done;
      logic                            res_flt;
      logic                            cfg_flt;
      logic                            busy;
      logic                            link_ok;
      logic                            clk_rec;
      logic [2:0]                      ctrl;
      logic [msr_pkg::EV_W-1:0]        ev_stat;
      logic [msr_pkg::EV_W-1:0]        ev_en;
      logic                            irq;
      logic                            awready;
      logic                            wready;
      logic                            aw_have;
      logic                            w_have;
      logic [7:0]                      awaddr;
      logic [31:0]                     wdata;
      logic                            wstrb0;
      logic                            bvalid;
      logic [1:0]                      bresp;
      logic                            arready;
      logic                            rvalid;
      logic [31:0]                     rdata;
      logic [1:0]                      rresp;
   } msr_regs_type;

   msr_regs_type s_r;
   msr_regs_type s_nxt;

   logic [msr_pkg::EV_W-1:0] ev_set;
   logic [31:0]              status_w;

   always_comb begin
      status_w = 32'h0;
      status_w[msr_pkg::ST_DONE]    = s_r.done;
      status_w[msr_pkg::ST_MASTER]  = s_r.master;
      status_w[msr_pkg::ST_RES_FLT] = s_r.res_flt;
      status_w[msr_pkg::ST_CFG_FLT] = s_r.cfg_flt;
      status_w[msr_pkg::ST_LINK_OK] = s_r.link_ok;
      status_w[msr_pkg::ST_CLK_REC] = s_r.clk_rec;
      status_w[msr_pkg::ST_CNT_LSB +: msr_pkg::CNT_W] = s_r.cnt;
      // Busy bit reads zero after completion
      status_w[msr_pkg::ST_BUSY] = s_r.busy;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic start;
      logic do_wr;
      logic [msr_pkg::EV_W-1:0] ev_clr;
      start  = 1'b0;
      do_wr  = 1'b0;
      ev_clr = '0;
      ev_set = '0;
      s_nxt  = s_r;
      s_nxt.loc_valid = 1'b0;
      // Free-running seed source, never all zero
      s_nxt.lfsr = s_r.lfsr[0] ? ((s_r.lfsr >> 1) ^ msr_pkg::LFSR_TAPS)
                               : (s_r.lfsr >> 1);

      // Write channel: address and data accepted in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.awaddr  = s_axi_awaddr;
         s_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata  = s_axi_wdata;
         s_nxt.wstrb0 = s_axi_wstrb[0];
         s_nxt.wready = 1'b0;
      end
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         do_wr = s_r.wstrb0;
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = msr_pkg::RESP_OKAY;
         case (s_r.awaddr)
            msr_pkg::CTRL_OFS: begin
               if (do_wr) begin
                  s_nxt.ctrl = s_r.wdata[2:0];
                  start      = s_r.wdata[msr_pkg::CTRL_START];
               end
            end
            msr_pkg::IRQ_CLR_OFS: begin
               if (do_wr) begin
                  ev_clr = s_r.wdata[msr_pkg::EV_W-1:0];
               end
            end
            msr_pkg::IRQ_EN_OFS: begin
               if (do_wr) begin
                  s_nxt.ev_en = s_r.wdata[msr_pkg::EV_W-1:0];
               end
            end
            msr_pkg::STATUS_OFS, msr_pkg::IRQ_STAT_OFS,
            msr_pkg::SEED_OFS: begin
            end
            default: begin
               s_nxt.bresp = msr_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid  = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready  = 1'b1;
      end

      // Read channel
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid  = 1'b1;
         s_nxt.rresp   = msr_pkg::RESP_OKAY;
         case (s_axi_araddr)
            msr_pkg::CTRL_OFS:     s_nxt.rdata = {29'h0, s_r.ctrl};
            msr_pkg::STATUS_OFS:   s_nxt.rdata = status_w;
            msr_pkg::IRQ_STAT_OFS: s_nxt.rdata = {29'h0, s_r.ev_stat};
            msr_pkg::IRQ_CLR_OFS:  s_nxt.rdata = 32'h0;
            msr_pkg::IRQ_EN_OFS:   s_nxt.rdata = {29'h0, s_r.ev_en};
            msr_pkg::SEED_OFS:     s_nxt.rdata = {21'h0, s_r.seed};
            default: begin
               s_nxt.rdata = 32'h0;
               s_nxt.rresp = msr_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid  = 1'b0;
         s_nxt.arready = 1'b1;
      end

      // Resolution
      case (s_r.st)
         msr_pkg::MSR_IDLE: begin
         end
         msr_pkg::MSR_SEND: begin
            s_nxt.seed      = s_r.lfsr;
            s_nxt.loc_valid = 1'b1;
            s_nxt.cnt       = s_r.cnt + 3'h1;
            s_nxt.st        = msr_pkg::MSR_WAIT;
         end
         msr_pkg::MSR_WAIT: begin
            if (lp_valid) begin
               s_nxt.st = msr_pkg::MSR_DONE;
               if (s_r.ctrl[msr_pkg::CTRL_MAN_EN] && lp_man_en &&
                   (s_r.ctrl[msr_pkg::CTRL_MAN_MST] == lp_man_mst)) begin
                  s_nxt.cfg_flt = 1'b1;
                  s_nxt.master  = 1'b0;
               end else if (s_r.ctrl[msr_pkg::CTRL_MAN_EN]) begin
                  s_nxt.master = s_r.ctrl[msr_pkg::CTRL_MAN_MST];
               end else if (lp_man_en) begin
                  s_nxt.master = !lp_man_mst;
               end else if (s_r.ctrl[msr_pkg::CTRL_LOOP_SUP] != lp_loop_sup)
               begin
                  s_nxt.master = lp_loop_sup;
               end else if (s_r.seed != lp_seed) begin
                  s_nxt.master = s_r.seed > lp_seed;
               end else if (s_r.cnt == msr_pkg::MAX_SEEDS) begin
                  s_nxt.res_flt = 1'b1;
                  s_nxt.master  = 1'b0;
               end else begin
                  s_nxt.st = msr_pkg::MSR_SEND;
               end
            end
         end
         msr_pkg::MSR_DONE: begin
            // Conflict and success both end here as complete
            s_nxt.done    = 1'b1;
            s_nxt.busy    = 1'b0;
            s_nxt.cnt     = '0;
            s_nxt.link_ok = !s_r.cfg_flt && !s_r.res_flt;
            s_nxt.clk_rec = !s_r.master && s_r.ctrl[msr_pkg::CTRL_LOOP_SUP]
                            && !s_r.cfg_flt && !s_r.res_flt;
            ev_set[msr_pkg::EV_DONE]    = !s_r.done;
            ev_set[msr_pkg::EV_RES_FLT] = !s_r.done && s_r.res_flt;
            ev_set[msr_pkg::EV_CFG_FLT] = !s_r.done && s_r.cfg_flt;
            s_nxt.st = msr_pkg::MSR_IDLE;
         end
         default: begin
            s_nxt.st = msr_pkg::MSR_IDLE;
         end
      endcase

      // A new start restarts the attempt from a cleared counter
      if (start || an_start) begin
         s_nxt.st      = msr_pkg::MSR_SEND;
         s_nxt.cnt     = '0;
         s_nxt.done    = 1'b0;
         s_nxt.busy    = 1'b1;
         s_nxt.res_flt = 1'b0;
         s_nxt.cfg_flt = 1'b0;
         s_nxt.link_ok = 1'b0;
         s_nxt.clk_rec = 1'b0;
      end

      // Set wins over a clear in the same cycle
      s_nxt.ev_stat = (s_r.ev_stat & ~ev_clr) | ev_set;
      s_nxt.irq     = |(s_nxt.ev_stat & s_nxt.ev_en);
   end

   // ------------------------------------------------------------
   // Register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_r         <= '0;
         s_r.st      <= msr_pkg::MSR_IDLE;
         s_r.lfsr    <= msr_pkg::LFSR_RST;
         s_r.ctrl    <= msr_pkg::CTRL_RST;
         s_r.ev_en   <= msr_pkg::IRQ_EN_RST;
         s_r.awready <= 1'b1;
         s_r.wready  <= 1'b1;
         s_r.arready <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign loc_valid          = s_r.loc_valid;
   assign loc_man_en         = s_r.ctrl[msr_pkg::CTRL_MAN_EN];
   assign loc_man_mst        = s_r.ctrl[msr_pkg::CTRL_MAN_MST];
   assign loc_loop_sup       = s_r.ctrl[msr_pkg::CTRL_LOOP_SUP];
   assign loc_seed           = s_r.seed;
   assign role_master        = s_r.master;
   assign res_done           = s_r.done;
   assign res_fault          = s_r.res_flt;
   assign cfg_fault          = s_r.cfg_flt;
   assign link_ok_indication = s_r.link_ok;
   assign clk_sel_recovered  = s_r.clk_rec;
   assign irq                = s_r.irq;
   assign s_axi_awready      = s_r.awready;
   assign s_axi_wready       = s_r.wready;
   assign s_axi_bvalid       = s_r.bvalid;
   assign s_axi_bresp        = s_r.bresp;
   assign s_axi_arready      = s_r.arready;
   assign s_axi_rvalid       = s_r.rvalid;
   assign s_axi_rdata        = s_r.rdata;
   assign s_axi_rresp        = s_r.rresp;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence page_sent_s;
      ce && !an_start && s_r.st == msr_pkg::MSR_SEND;
   endsequence
   sequence page_out_s;
      s_r.loc_valid && s_r.st == msr_pkg::MSR_WAIT;
   endsequence

   page_emit_a: assert property (page_sent_s |=> page_out_s)
      else $error("local page not emitted");
   cnt_step_a: assert property (
      page_sent_s |=> s_r.cnt == $past(s_r.cnt) + 3'h1)
      else $error("seed counter did not advance");
   done_clr_a: assert property (res_done |-> s_r.cnt == 3'h0 && !s_r.busy)
      else $error("counter or busy not clear after completion");
   seed_fault_a: assert property (
      ce && !an_start && s_r.st == msr_pkg::MSR_WAIT && lp_valid &&
      !s_r.ctrl[0] && !lp_man_en && s_r.ctrl[2] == lp_loop_sup &&
      s_r.seed == lp_seed && s_r.cnt == 3'h7 |=> res_fault)
      else $error("no fault after seven seeds");
   loop_slave_a: assert property (
      ce && !an_start && s_r.st == msr_pkg::MSR_WAIT && lp_valid &&
      !s_r.ctrl[0] && !lp_man_en && s_r.ctrl[2] && !lp_loop_sup
      |=> !role_master)
      else $error("loop timing end not slave");
   cfg_conf_a: assert property (
      ce && !an_start && s_r.st == msr_pkg::MSR_WAIT && lp_valid &&
      s_r.ctrl[0] && lp_man_en && s_r.ctrl[1] == lp_man_mst
      |=> cfg_fault ##1 (res_done || s_r.st != msr_pkg::MSR_IDLE))
      else $error("role conflict not handled");
   link_fail_a: assert property (cfg_fault |-> !link_ok_indication)
      else $error("link ok during role conflict");
   clk_src_a: assert property (clk_sel_recovered |-> !role_master)
      else $error("master on recovered clock");
   // Level follows the registered status and enable, never a stale copy
   irq_lvl_a: assert property (irq == |(s_r.ev_stat & s_r.ev_en))
      else $error("interrupt level mismatch");
endmodule // msr_resolver

/* test/master_slave_resolution_test.sv */
`timescale 1ns/10ps
module master_slave_resolution_test;
   logic        clk_sys = 1'b0, rst_n = 1'b0, an_start = 1'b0;
   logic        ce = 1'b1;
   logic        lp_valid, lp_man_en, lp_man_mst, lp_loop_sup, loc_valid;
   logic        loc_man_en, loc_man_mst, loc_loop_sup, role_master, irq;
   logic        res_done, res_fault, cfg_fault;
   logic        link_ok_indication, clk_sel_recovered;
   logic [10:0] lp_seed, loc_seed, cap_loc, cap_lp, p_seed = 11'h000;
   logic        p_man_en = 1'b0, p_man_mst = 1'b0, p_loop = 1'b0;
   logic [1:0]  p_mode = 2'h0;
   logic [3:0]  p_delay = 4'h0, s_axi_wstrb = 4'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [8:0]  v;
   int          err_count = 0, total_checks = 0, npages = 0, sd;

   msr_resolver dut_u (.clk_sys, .rst_n, .ce, .an_start, .lp_valid,
      .lp_man_en, .lp_man_mst, .lp_loop_sup, .lp_seed, .loc_valid,
      .loc_man_en, .loc_man_mst, .loc_loop_sup, .loc_seed, .role_master,
      .res_done, .res_fault, .cfg_fault, .link_ok_indication,
      .clk_sel_recovered, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   msr_partner partner_u (.clk_sys, .rst_n, .loc_valid, .loc_seed,
      .man_en(p_man_en), .man_mst(p_man_mst), .loop_sup(p_loop),
      .seed_mode(p_mode), .seed_val(p_seed), .delay(p_delay), .lp_valid,
      .lp_man_en, .lp_man_mst, .lp_loop_sup, .lp_seed);

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (loc_valid) npages <= npages + 1;
      if (lp_valid) begin
         cap_loc <= loc_seed;
         cap_lp  <= lp_seed;
      end
   end
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Returns {conflict, master}; v = {lm_en,lm_mst,ll,pm_en,pm_mst,pl,..}
   function automatic logic [1:0] exp_res(input logic [8:0] c,
                                          input logic [10:0] ls, ps);
      if (c[8] && c[5] && c[7] == c[4]) return 2'b10;
      if (c[8]) return {1'b0, c[7]};
      if (c[5]) return {1'b0, !c[4]};
      if (c[6] != c[3]) return {1'b0, !c[6]};
      return {1'b0, ls > ps};
   endfunction
   // ----------------------------------------
   // Register bus master
   // ----------------------------------------
   task axw(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
      logic ad, wt;
      ad = 0; wt = 0;
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, wd, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk_sys);
         if (!ad && s_axi_awready) begin s_axi_awvalid <= 1'b0; ad = 1; end
         if (!wt && s_axi_wready) begin s_axi_wvalid <= 1'b0; wt = 1; end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge clk_sys);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      {r, d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
   endtask
   // ----------------------------------------
   // One resolution round
   // ----------------------------------------
   task run_case(input logic [8:0] c, input logic en);
      int n, np0;
      logic [1:0] e;
      axw(msr_pkg::CTRL_OFS, {29'h0, c[6], c[7], c[8]}, 4'hF);
      axw(msr_pkg::IRQ_EN_OFS, en ? 32'h7 : 32'h0, 4'hF);
      chk({loc_loop_sup, loc_man_mst, loc_man_en}, {c[6], c[7], c[8]});
      {p_man_en, p_man_mst, p_loop, p_mode} <= c[5:1];
      p_delay <= 4'($urandom_range(5));
      p_seed  <= 11'($urandom);
      np0 = npages;
      if (c[0]) axw(msr_pkg::CTRL_OFS, {28'h1, c[6], c[7], c[8]}, 4'hF);
      else begin
         @(posedge clk_sys) an_start <= 1'b1;
         @(posedge clk_sys) an_start <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      n = 0;
      while (!res_done && !res_fault && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (2) @(posedge clk_sys);
      #1;
      chk(n < 400, 1);
      e = exp_res(c, cap_loc, cap_lp);
      axr(msr_pkg::IRQ_STAT_OFS);
      if (c[2:1] == 2'h1) begin
         chk({res_fault, role_master}, 2'b10);
         chk(res_done, 1);
         chk(npages - np0, 7);
         chk(d[msr_pkg::EV_RES_FLT], 1);
      end else begin
         chk(res_done, 1);
         chk(cfg_fault, e[1]);
         chk(role_master, e[0]);
         chk(link_ok_indication, !e[1]);
         chk(clk_sel_recovered, c[6] && !e[0] && !e[1]);
         chk({d[msr_pkg::EV_CFG_FLT], d[msr_pkg::EV_DONE]}, {e[1], 1'b1});
         if (c[2:1] == 2'h2) chk(npages - np0, 1);
         axr(msr_pkg::STATUS_OFS);
         chk({d[15], d[10:8], d[5:3], d[1:0]},
             {4'h0, c[6] && !e[0] && !e[1], !e[1], e, 1'b1});
         axr(msr_pkg::SEED_OFS);
         chk(d, {21'h0, cap_loc});
      end
      chk(irq, en);
      axw(msr_pkg::IRQ_CLR_OFS, 32'h7, 4'hF);
      repeat (2) @(posedge clk_sys);
      chk(irq, 0);
      axr(msr_pkg::IRQ_STAT_OFS);
      chk(d[2:0], 0);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   logic [8:0] cases [10] = '{9'b110110100, 9'b101100101, 9'b110101100,
      9'b100001101, 9'b001110100, 9'b001000101, 9'b000001100,
      9'b001001101, 9'b000000000, 9'b001001010};
   initial begin
      #500000;
      err_count++;
      finish_test;
   end
   initial begin
      sd = $urandom(32'h6FAD);
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      axr(msr_pkg::STATUS_OFS);
      chk({d[10:8], d[0]}, 4'h0);
      axr(msr_pkg::IRQ_EN_OFS);
      chk(d[2:0], msr_pkg::IRQ_EN_RST);
      axr(8'h18);
      chk({r, d}, {msr_pkg::RESP_SLVERR, 32'h0});
      axw(8'h1C, 32'hFFFFFFFF, 4'hF);
      chk(r, msr_pkg::RESP_SLVERR);
      axw(msr_pkg::CTRL_OFS, 32'h7, 4'hE);
      chk({r, loc_man_en}, {msr_pkg::RESP_OKAY, 1'b0});
      axr(msr_pkg::IRQ_CLR_OFS);
      chk(d, 0);
      for (int i = 0; i < 10; i++) run_case(cases[i], i[0]);
      // Frozen block ignores a start; a mid-run reset then clears it
      ce <= 1'b0;
      an_start <= 1'b1;
      @(posedge clk_sys) an_start <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({res_done, res_fault, loc_valid}, 3'h6);
      ce <= 1'b1;
      rst_n <= 1'b0;
      @(posedge clk_sys) rst_n <= 1'b1;
      axr(msr_pkg::STATUS_OFS);
      chk({d[15], d[10:8], d[3:0]}, 8'h0);
      for (int i = 0; i < 8; i++) begin
         v = 9'($urandom);
         v[1] = 1'b0;
         run_case(v, i[1]);
      end
      finish_test;
   end
endmodule // master_slave_resolution_test

/* test/msr_partner.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Link partner page exchange model
// ----------------------------------------
module msr_partner (
   input  wire logic                       clk_sys,     // System clock
   input  wire logic                       rst_n,       // Async reset
   input  wire logic                       loc_valid,   // Local page
   input  wire logic [msr_pkg::SEED_W-1:0] loc_seed,    // Local seed
   input  wire logic                       man_en,      // Manual mode
   input  wire logic                       man_mst,     // Manual MASTER
   input  wire logic                       loop_sup,    // Loop timing
   input  wire logic [1:0]                 seed_mode,   // 1 tie 2 invert
   input  wire logic [msr_pkg::SEED_W-1:0] seed_val,    // Fixed seed
   input  wire logic [3:0]                 delay,       // Answer delay
   output logic                            lp_valid,    // Page valid
   output logic                            lp_man_en,   // Page manual
   output logic                            lp_man_mst,  // Page MASTER
   output logic                            lp_loop_sup, // Page loop
   output logic [msr_pkg::SEED_W-1:0]      lp_seed      // Page seed
);
   logic                       pend;
   logic [3:0]                 cnt;
   logic [msr_pkg::SEED_W-1:0] ans;

   // The latest local page gets exactly one answer page
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {pend, cnt, ans, lp_valid} <= '0;
         {lp_man_en, lp_man_mst, lp_loop_sup, lp_seed} <= '0;
      end else begin
         lp_valid <= 1'b0;
         // Released page lines flicker so a stale value never passes
         {lp_man_en, lp_man_mst, lp_loop_sup, lp_seed} <=
            ~{lp_man_en, lp_man_mst, lp_loop_sup, lp_seed};
         if (loc_valid) begin
            pend <= 1'b1;
            cnt  <= delay;
            // Tie and inverse seeds steer the seed comparison
            ans  <= (seed_mode == 2'h1) ? loc_seed :
                    (seed_mode == 2'h2) ? ~loc_seed : seed_val;
         end else if (pend && cnt == 4'h0) begin
            pend        <= 1'b0;
            lp_valid    <= 1'b1;
            lp_man_en   <= man_en;
            lp_man_mst  <= man_mst;
            lp_loop_sup <= loop_sup;
            lp_seed     <= ans;
         end else if (pend) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // msr_partner
